/* File: design/merr_pkg.sv */
// Constants, field layout and carrier types of the memory error reporting block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses and one core clock.
// Contract
// R1 - Four fatal indications, bits 0..3, latch on error, clear on read.
// R2 - Masked-in fatal indication sets interrupt cause; mask bits reset to one.
// R3 - Buffer ECC enable bit 0 resets one; correctable flag bit 2 is write-one-clear.
// R4 - Global parity enable clear disables parity checking on all internal RAMs.
// R5 - Global parity enable reset only by LAN power good, loaded from flash.
// R6 - Queue parity check enables at bits 6,8,10,12 reset to one.
// R7 - Status bits 3..6 record queue parity errors while enabled; write one clears.
// R8 - Any queue parity error halts all host link and DMA traffic.
// R9 - Software recovers from queue parity error by software reset and reinit.
// R10 - Queue parity error sets host link fatal indication and interrupt cause.
// R11 - ECC check enables at bits 12 and 14 reset to one.
// R12 - Bits 4 and 5 flag correctable ECC errors; write one clears.
// R13 - Four read-only 16-bit access-control values, zero at host link reset.
// R14 - Software writes zero to reserved fields and ignores them on read.
// R15 - Buffer ECC disabled: no correction and no correctable flag.
package merr_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [15:0] MERR_FATAL_IND_ADDR = 16'h1084;
    localparam logic [15:0] MERR_FATAL_MASK_ADDR = 16'h1088;
    localparam logic [15:0] MERR_PB_ECC_ADDR = 16'h245C;
    localparam logic [15:0] MERR_ACL_LO_ADDR = 16'h5B7C;
    localparam logic [15:0] MERR_ACL_HI_ADDR = 16'h5B80;
    localparam logic [15:0] MERR_PAR_CTL_ADDR = 16'h5BA0;
    localparam logic [15:0] MERR_ECC_CTL_ADDR = 16'h5BA4;
    localparam logic [15:0] MERR_PAR_STS_ADDR = 16'h5BA8;
    localparam logic [15:0] MERR_ECC_STS_ADDR = 16'h5BAC;
    localparam logic [15:0] MERR_IRQ_STS_ADDR = 16'h5BC0;
    localparam logic [15:0] MERR_IRQ_MASK_ADDR = 16'h5BC4;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MERR_FATAL_PCIE_BIT = 2;
    localparam logic [3:0] MERR_FATAL_MASK_RST = 4'hF;
    localparam int MERR_PB_EN_BIT = 0;
    localparam int MERR_PB_FLAG_BIT = 2;
    localparam int MERR_GPAR_BIT = 0;
    localparam int MERR_QEN_BIT0 = 6;
    localparam int MERR_QERR_BIT0 = 3;
    localparam int MERR_ECC_WR_EN_BIT = 12;
    localparam int MERR_ECC_RB_EN_BIT = 14;
    localparam int MERR_ECC_WR_ERR_BIT = 4;
    localparam int MERR_ECC_RB_ERR_BIT = 5;
    localparam logic [31:0] MERR_PAR_CTL_RSVD = 32'h0000_0010;
    localparam logic [31:0] MERR_ECC_CTL_RSVD = 32'h0000_0511;
    localparam logic [3:0] MERR_IRQ_MASK_RST = 4'h0;
    localparam logic [31:0] MERR_UNMAPPED_DATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] fatal;
        logic pb_correctable;
        logic [3:0] queue_parity;
        logic ecc_wr_data;
        logic ecc_retry_buf;
    } merr_events_t;

    typedef struct packed {
        logic [15:0] value_3;
        logic [15:0] value_2;
        logic [15:0] value_1;
        logic [15:0] value_0;
    } merr_acl_t;

    typedef enum logic [1:0] {
        MERR_IRQ_FATAL,
        MERR_IRQ_QUEUE,
        MERR_IRQ_CORR,
        MERR_IRQ_SPARE
    } merr_irq_bit_t;

endpackage

/* File: design/merr_top.sv */
// Memory error enable and reporting registers with a Wishbone slave port.
// Assumes error pulses arrive synchronous to clk_i, one cycle per detected error.
`timescale 1ns/1ns
module merr_top
    import merr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lan_power_good_reset_i,
    input wire logic host_link_reset_i,
    input wire logic flash_global_parity_enable_i,
    input wire logic flash_load_i,
    input wire merr_events_t events_i,
    input wire merr_acl_t acl_i,
    input wire logic acl_load_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic fatal_error_interrupt_cause_o,
    output logic global_parity_enable_o,
    output logic [3:0] queue_check_enable_o,
    output logic [1:0] ecc_check_enable_o,
    output logic pb_ecc_enable_o,
    output logic traffic_halt_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
        hit = (a[15:2] == base[15:2]);
    endfunction

    logic req;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    logic [31:0] wd;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wd = wb_dat_i & wmask;

    logic [3:0] fatal_r;
    logic [3:0] fmask_r;
    logic pb_en_r;
    logic pb_flag_r;
    logic gpar_r;
    logic [3:0] qen_r;
    logic [3:0] qerr_r;
    logic [1:0] ecc_en_r;
    logic [1:0] ecc_err_r;
    merr_acl_t acl_r;
    logic [3:0] irq_sts_r;
    logic [3:0] irq_mask_r;
    logic [3:0] qerr_set;
    logic [3:0] fatal_set;
    logic [3:0] irq_set;

    // ------------------------------------------------------------
    // Error detection qualifiers
    // ------------------------------------------------------------
    // Queue parity is gated both by its own enable and by the global enable.
    assign qerr_set = events_i.queue_parity & qen_r & {4{gpar_r}}; // [R7] [R4]
    always_comb
    begin
        fatal_set = events_i.fatal;
        fatal_set[MERR_FATAL_PCIE_BIT] = events_i.fatal[MERR_FATAL_PCIE_BIT] | (|qerr_set); // [R10]
    end

    // ------------------------------------------------------------
    // Fatal indication and mask
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fatal_r <= 4'h0;
        else if (rd && hit(wb_adr_i, MERR_FATAL_IND_ADDR))
            fatal_r <= fatal_set; // [R1] set wins over clear on read
        else
            fatal_r <= fatal_r | fatal_set; // [R1]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fmask_r <= MERR_FATAL_MASK_RST; // [R2]
        else if (wr && hit(wb_adr_i, MERR_FATAL_MASK_ADDR))
            fmask_r <= (fmask_r & ~wmask[3:0]) | wd[3:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fatal_error_interrupt_cause_o <= 1'b0;
        else
            fatal_error_interrupt_cause_o <= |(fatal_r & fmask_r); // [R2] [R10]
    end

    // ------------------------------------------------------------
    // Packet buffer ECC
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pb_en_r <= 1'b1; // [R3]
        else if (wr && hit(wb_adr_i, MERR_PB_ECC_ADDR) && wb_sel_i[0])
            pb_en_r <= wb_dat_i[MERR_PB_EN_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pb_flag_r <= 1'b0;
        else if (events_i.pb_correctable && pb_en_r)
            pb_flag_r <= 1'b1; // [R3] [R15]
        else if (wr && hit(wb_adr_i, MERR_PB_ECC_ADDR) && wd[MERR_PB_FLAG_BIT])
            pb_flag_r <= 1'b0; // [R3]
    end

    // ------------------------------------------------------------
    // Global parity enable, on the LAN power good reset only
    // ------------------------------------------------------------
    // Neither rst_i nor the host link reset touches this bit, by design.
    always_ff @(posedge clk_i)
    begin
        if (lan_power_good_reset_i)
            gpar_r <= 1'b0; // [R5]
        else if (flash_load_i)
            gpar_r <= flash_global_parity_enable_i; // [R5]
        else if (wr && hit(wb_adr_i, MERR_PAR_CTL_ADDR) && wb_sel_i[0])
            gpar_r <= wb_dat_i[MERR_GPAR_BIT];
    end

    // ------------------------------------------------------------
    // Queue parity enables and status
    // ------------------------------------------------------------
    genvar q;
    generate
        for (q = 0; q < 4; q++)
        begin : g_queue
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    qen_r[q] <= 1'b1; // [R6]
                else if (wr && hit(wb_adr_i, MERR_PAR_CTL_ADDR) && wmask[MERR_QEN_BIT0 + 2 * q])
                    qen_r[q] <= wb_dat_i[MERR_QEN_BIT0 + 2 * q];
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    qerr_r[q] <= 1'b0;
                else if (qerr_set[q])
                    qerr_r[q] <= 1'b1; // [R7]
                else if (wr && hit(wb_adr_i, MERR_PAR_STS_ADDR) && wd[MERR_QERR_BIT0 + q])
                    qerr_r[q] <= 1'b0; // [R7]
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            traffic_halt_o <= 1'b0;
        else
            traffic_halt_o <= (|qerr_r) | (|qerr_set); // [R8]
    end

    // ------------------------------------------------------------
    // Host link ECC enables and status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ecc_en_r <= 2'h3; // [R11]
        else if (wr && hit(wb_adr_i, MERR_ECC_CTL_ADDR) && wb_sel_i[1])
            ecc_en_r <= {wb_dat_i[MERR_ECC_RB_EN_BIT], wb_dat_i[MERR_ECC_WR_EN_BIT]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ecc_err_r <= 2'h0;
        else
        begin
            if (events_i.ecc_wr_data && ecc_en_r[0])
                ecc_err_r[0] <= 1'b1; // [R12]
            else if (wr && hit(wb_adr_i, MERR_ECC_STS_ADDR) && wd[MERR_ECC_WR_ERR_BIT])
                ecc_err_r[0] <= 1'b0; // [R12]
            if (events_i.ecc_retry_buf && ecc_en_r[1])
                ecc_err_r[1] <= 1'b1; // [R12]
            else if (wr && hit(wb_adr_i, MERR_ECC_STS_ADDR) && wd[MERR_ECC_RB_ERR_BIT])
                ecc_err_r[1] <= 1'b0; // [R12]
        end
    end

    // ------------------------------------------------------------
    // Access control values
    // ------------------------------------------------------------
    // Only the host link side loads these; bus writes are dropped.
    always_ff @(posedge clk_i)
    begin
        if (host_link_reset_i)
            acl_r <= '0; // [R13]
        else if (acl_load_i)
            acl_r <= acl_i; // [R13]
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // A plain net keeps the status set path sensitive to every event and enable it reads.
    logic [1:0] ecc_set;
    assign ecc_set = {events_i.ecc_retry_buf & ecc_en_r[1], events_i.ecc_wr_data & ecc_en_r[0]};
    assign irq_set = {1'b0, (|ecc_set) | (events_i.pb_correctable & pb_en_r), |qerr_set, |fatal_set};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_sts_r <= 4'h0;
        else if (wr && hit(wb_adr_i, MERR_IRQ_STS_ADDR))
            irq_sts_r <= (irq_sts_r & ~wd[3:0]) | irq_set;
        else
            irq_sts_r <= irq_sts_r | irq_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask_r <= MERR_IRQ_MASK_RST;
        else if (wr && hit(wb_adr_i, MERR_IRQ_MASK_ADDR))
            irq_mask_r <= (irq_mask_r & ~wmask[3:0]) | wd[3:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_sts_r & irq_mask_r);
    end

    // ------------------------------------------------------------
    // Enable outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            queue_check_enable_o <= 4'hF;
            ecc_check_enable_o <= 2'h3;
            pb_ecc_enable_o <= 1'b1;
            global_parity_enable_o <= 1'b0;
        end
        else
        begin
            queue_check_enable_o <= qen_r & {4{gpar_r}}; // [R4]
            ecc_check_enable_o <= ecc_en_r; // [R11]
            pb_ecc_enable_o <= pb_en_r; // [R15]
            global_parity_enable_o <= gpar_r; // [R4]
        end
    end

    // ------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------
    // Reserved bits read back as fixed values, so software must mask them.
    logic [31:0] rdata;
    always_comb
    begin
        rdata = MERR_UNMAPPED_DATA;
        if (hit(wb_adr_i, MERR_FATAL_IND_ADDR))
            rdata[3:0] = fatal_r;
        else if (hit(wb_adr_i, MERR_FATAL_MASK_ADDR))
            rdata[3:0] = fmask_r;
        else if (hit(wb_adr_i, MERR_PB_ECC_ADDR))
        begin
            rdata[MERR_PB_EN_BIT] = pb_en_r;
            rdata[MERR_PB_FLAG_BIT] = pb_flag_r;
        end
        else if (hit(wb_adr_i, MERR_ACL_LO_ADDR))
            rdata = {acl_r.value_1, acl_r.value_0};
        else if (hit(wb_adr_i, MERR_ACL_HI_ADDR))
            rdata = {acl_r.value_3, acl_r.value_2};
        else if (hit(wb_adr_i, MERR_PAR_CTL_ADDR))
        begin
            rdata = MERR_PAR_CTL_RSVD; // [R14]
            rdata[MERR_GPAR_BIT] = gpar_r;
            rdata[MERR_QEN_BIT0] = qen_r[0];
            rdata[MERR_QEN_BIT0 + 2] = qen_r[1];
            rdata[MERR_QEN_BIT0 + 4] = qen_r[2];
            rdata[MERR_QEN_BIT0 + 6] = qen_r[3];
        end
        else if (hit(wb_adr_i, MERR_ECC_CTL_ADDR))
        begin
            rdata = MERR_ECC_CTL_RSVD; // [R14]
            rdata[MERR_ECC_WR_EN_BIT] = ecc_en_r[0];
            rdata[MERR_ECC_RB_EN_BIT] = ecc_en_r[1];
        end
        else if (hit(wb_adr_i, MERR_PAR_STS_ADDR))
            rdata[6:3] = qerr_r;
        else if (hit(wb_adr_i, MERR_ECC_STS_ADDR))
            rdata[5:4] = ecc_err_r;
        else if (hit(wb_adr_i, MERR_IRQ_STS_ADDR))
            rdata[3:0] = irq_sts_r;
        else if (hit(wb_adr_i, MERR_IRQ_MASK_ADDR))
            rdata[3:0] = irq_mask_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= rd ? rdata : 32'h0000_0000;
        end
    end

endmodule

/* File: verif/merr_properties.sv */
// Concurrent checks on the ports of the memory error reporting block.
// Assumes one core clock and the synchronous active-high reset rst_i.
`timescale 1ns/1ns
module merr_properties
    import merr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire merr_events_t events_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic fatal_error_interrupt_cause_o,
    input wire logic global_parity_enable_o,
    input wire logic [3:0] queue_check_enable_o,
    input wire logic [1:0] ecc_check_enable_o,
    input wire logic pb_ecc_enable_o,
    input wire logic traffic_halt_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [3:0] qual;
    logic [3:0] qhist_r;
    assign qual = events_i.queue_parity & queue_check_enable_o;
    // The cause path from a queue error may pass through the indication, so a short history is kept.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            qhist_r <= 4'h0;
        else
            qhist_r <= {qhist_r[2:0], |qual};
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack stood longer than one cycle.");
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle.");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without a request.");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack.");
    property p_halt_set; |qual |-> ##[1:2] traffic_halt_o; endproperty
    a_halt_set: assert property (p_halt_set) else $error("queue error did not halt traffic.");
    property p_halt_hold; !rst_i && traffic_halt_o && !wb_cyc_i && !$past(wb_cyc_i) |=> traffic_halt_o; endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt dropped without a bus write.");
    property p_cause_src;
        $rose(fatal_error_interrupt_cause_o) |-> $past(|events_i.fatal, 2) || (|qhist_r[3:1]);
    endproperty
    a_cause_src: assert property (p_cause_src) else $error("fatal cause rose without an error.");
    property p_global_gate;
        !global_parity_enable_o && !$past(rst_i) && !$past(|qual) && |events_i.queue_parity && !traffic_halt_o
            |=> !traffic_halt_o;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("halt while parity disabled.");
    property p_reset_vals;
        $fell(rst_i) |-> ecc_check_enable_o == 2'b11 && pb_ecc_enable_o && !traffic_halt_o && !irq_o
            && !fatal_error_interrupt_cause_o;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong levels after reset.");
endmodule

bind merr_top merr_properties i_merr_properties (.clk_i(clk_i), .rst_i(rst_i), .events_i(events_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fatal_error_interrupt_cause_o(fatal_error_interrupt_cause_o), .global_parity_enable_o(global_parity_enable_o),
    .queue_check_enable_o(queue_check_enable_o), .ecc_check_enable_o(ecc_check_enable_o),
    .pb_ecc_enable_o(pb_ecc_enable_o), .traffic_halt_o(traffic_halt_o), .irq_o(irq_o));

/* File: verif/tb.sv */
// Self-checking bench of the memory error reporting block.
// Assumes a classic Wishbone slave that answers one cycle after it takes a request.
`timescale 1ns/1ns
module tb
    import merr_pkg::*;
;
    logic clk_i, rst_i, lpg, hlr, fgpe, fload, aload, we, cyc, stb, ack, cause, gpe, pben, halt, irq;
    logic [15:0] adr;
    logic [31:0] wdat, rdat, seed, t1, t2;
    logic [3:0] sel, qen, m;
    logic [1:0] een;
    merr_events_t evs;
    merr_acl_t acl;
    logic [31:0] expq[$];
    int n_errors = 0, n_checks = 0, tmo = 0;
    merr_top i_merr_top (.clk_i(clk_i), .rst_i(rst_i), .lan_power_good_reset_i(lpg), .host_link_reset_i(hlr),
        .flash_global_parity_enable_i(fgpe), .flash_load_i(fload), .events_i(evs), .acl_i(acl), .acl_load_i(aload),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .fatal_error_interrupt_cause_o(cause), .global_parity_enable_o(gpe),
        .queue_check_enable_o(qen), .ecc_check_enable_o(een), .pb_ecc_enable_o(pben), .traffic_halt_o(halt),
        .irq_o(irq));
    // ------------------------------------------------------------
    // Clock, compares and bus tasks
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task check_lvl(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // The read data is judged by this watcher at the edge where ack is sampled high.
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
            check_word(rdat, (expq.size() != 0) ? expq.pop_front() : 32'hX);
        tmo++;
        if (tmo == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end
    task bus(input logic [15:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        bus(a, d, 1'b1);
    endtask
    task rd(input logic [15:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 32'h0, 1'b0);
    endtask
    task ev(input logic [10:0] v);
        @(posedge clk_i);
        evs <= merr_events_t'(v);
        @(posedge clk_i);
        evs <= '0;
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task pulse_lpg();
        @(posedge clk_i);
        lpg <= 1'b1;
        @(posedge clk_i);
        lpg <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'hD6D9A730;
        {rst_i, lpg, hlr} = 3'b111;
        {fgpe, fload, aload, we, cyc, stb} = 6'h00;
        adr = 16'h0; wdat = 32'h0; sel = 4'h0; evs = '0; acl = '0;
        repeat (6) @(posedge clk_i);
        {rst_i, lpg, hlr} <= 3'b000;
        rd(MERR_FATAL_IND_ADDR, 32'h0);
        rd(MERR_FATAL_MASK_ADDR, 32'hF);
        rd(MERR_PB_ECC_ADDR, 32'h1);
        rd(MERR_ACL_LO_ADDR, 32'h0);
        rd(MERR_ACL_HI_ADDR, 32'h0);
        rd(MERR_PAR_CTL_ADDR, 32'h1540 | MERR_PAR_CTL_RSVD);
        rd(MERR_ECC_CTL_ADDR, 32'h5000 | MERR_ECC_CTL_RSVD);
        rd(MERR_PAR_STS_ADDR, 32'h0);
        rd(MERR_ECC_STS_ADDR, 32'h0);
        rd(16'h1000, MERR_UNMAPPED_DATA);
        @(posedge clk_i);
        fgpe <= 1'b1; fload <= 1'b1;
        @(posedge clk_i);
        fload <= 1'b0;
        idle(2);
        check_lvl({gpe, een, pben}, 4'hF);
        check_lvl(qen, 4'hF);
        ev(11'h20);
        idle(2);
        check_lvl({3'h0, halt}, 4'h1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        idle(2);
        check_lvl({3'h0, gpe}, 4'h1);
        check_lvl({3'h0, halt}, 4'h0);
        rd(MERR_PAR_STS_ADDR, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            ev(11'h80 << k);
            idle(1);
            check_lvl({3'h0, cause}, 4'h1);
            rd(MERR_FATAL_IND_ADDR, 32'h1 << k);
            rd(MERR_FATAL_IND_ADDR, 32'h0);
        end
        t1 = xs();
        m = t1[3:0];
        wr(MERR_FATAL_MASK_ADDR, {28'h0, m});
        rd(MERR_FATAL_MASK_ADDR, {28'h0, m});
        for (int k = 0; k < 4; k++)
        begin
            ev(11'h80 << k);
            idle(1);
            check_lvl({3'h0, cause}, {3'h0, m[k]});
            rd(MERR_FATAL_IND_ADDR, 32'h1 << k);
        end
        wr(MERR_FATAL_MASK_ADDR, 32'hF);
        for (int q = 0; q < 4; q++)
        begin
            ev(11'h4 << q);
            idle(2);
            check_lvl({3'h0, halt}, 4'h1);
            check_lvl({3'h0, cause}, 4'h1);
            rd(MERR_PAR_STS_ADDR, 32'h8 << q);
            rd(MERR_FATAL_IND_ADDR, 32'h4);
            wr(MERR_PAR_STS_ADDR, 32'h8 << q);
            idle(3);
            check_lvl({3'h0, halt}, 4'h0);
        end
        wr(MERR_PAR_CTL_ADDR, 32'h1141);
        idle(2);
        check_lvl(qen, 4'hB);
        ev(11'h10);
        idle(2);
        check_lvl({3'h0, halt}, 4'h0);
        rd(MERR_PAR_STS_ADDR, 32'h0);
        wr(MERR_PAR_CTL_ADDR, 32'h1541);
        wr(MERR_IRQ_STS_ADDR, 32'h7);
        rd(MERR_IRQ_STS_ADDR, 32'h0);
        wr(MERR_IRQ_MASK_ADDR, 32'h2);
        ev(11'h4);
        idle(2);
        check_lvl({3'h0, irq}, 4'h1);
        wr(MERR_IRQ_MASK_ADDR, 32'h0);
        idle(2);
        check_lvl({3'h0, irq}, 4'h0);
        wr(MERR_IRQ_MASK_ADDR, 32'h2);
        wr(MERR_PAR_STS_ADDR, 32'h8);
        rd(MERR_FATAL_IND_ADDR, 32'h4);
        idle(2);
        check_lvl({3'h0, irq}, 4'h1);
        wr(MERR_IRQ_STS_ADDR, 32'h2);
        idle(2);
        check_lvl({3'h0, irq}, 4'h0);
        pulse_lpg();
        idle(1);
        check_lvl({gpe, 3'h0}, 4'h0);
        ev(11'h3C);
        idle(2);
        check_lvl({qen[0], 2'h0, halt}, 4'h0);
        rd(MERR_PAR_STS_ADDR, 32'h0);
        ev(11'h2);
        ev(11'h1);
        rd(MERR_ECC_STS_ADDR, 32'h30);
        wr(MERR_ECC_STS_ADDR, 32'h10);
        rd(MERR_ECC_STS_ADDR, 32'h20);
        wr(MERR_ECC_CTL_ADDR, 32'h0);
        idle(2);
        check_lvl({2'h0, een}, 4'h0);
        ev(11'h40);
        rd(MERR_PB_ECC_ADDR, 32'h5);
        wr(MERR_PB_ECC_ADDR, 32'h5);
        rd(MERR_PB_ECC_ADDR, 32'h1);
        wr(MERR_PB_ECC_ADDR, 32'h0);
        idle(2);
        check_lvl({3'h0, pben}, 4'h0);
        ev(11'h40);
        rd(MERR_PB_ECC_ADDR, 32'h0);
        t1 = xs();
        t2 = xs();
        @(posedge clk_i);
        acl <= {t1, t2}; aload <= 1'b1;
        @(posedge clk_i);
        aload <= 1'b0;
        wr(MERR_ACL_LO_ADDR, ~t2);
        rd(MERR_ACL_LO_ADDR, t2);
        rd(MERR_ACL_HI_ADDR, t1);
        @(posedge clk_i);
        hlr <= 1'b1;
        @(posedge clk_i);
        hlr <= 1'b0;
        rd(MERR_ACL_LO_ADDR, 32'h0);
        rd(MERR_ACL_HI_ADDR, 32'h0);
        idle(3);
        finish_test();
    end
endmodule
